// File: common/pmcg_pkg.sv
// Package for the power-mode and peripheral clock-gating block.
// Assumes a single 25 MHz system clock and an APB register port.
package pmcg_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_GATE1 = 8'h04;
	localparam logic [7:0] ADDR_GATE2 = 8'h08;
	localparam logic [7:0] ADDR_MODE = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

	// control register fields
	localparam int CTRL_STANDBY_BIT = 0;
	localparam int CTRL_LOW_SPEED_BIT = 1;
	localparam int CTRL_MED_SPEED_BIT = 2;
	localparam int CTRL_DIRECT_BIT = 3;
	localparam int CTRL_TA_SOURCE_BIT = 4;
	localparam int CTRL_DT_IRQ_EN_BIT = 5;
	localparam int CTRL_WAIT_LSB = 8;
	localparam int CTRL_WIDTH = 11;
	localparam logic [10:0] CTRL_RESET = 11'h000;

	// gate register layout
	localparam int GATE1_TIMER_A = 0;
	localparam int GATE1_TIMER_C = 1;
	localparam int GATE1_TIMER_F = 2;
	localparam int GATE1_TIMER_G = 3;
	localparam int GATE1_ADC = 4;
	localparam int GATE1_SERIAL_ONE = 5;
	localparam int GATE1_SERIAL_32 = 6;
	localparam int GATE1_SERIAL_31 = 7;
	localparam int GATE2_WATCHDOG = 0;
	localparam logic [7:0] GATE_RESET = 8'hFF;

	// interrupt status bits
	localparam int IRQ_DT_DONE = 0;
	localparam int IRQ_FALLBACK = 1;
	localparam int IRQ_WAKE = 2;
	localparam int IRQ_WIDTH = 3;

	// direct transition state counts
	localparam int DT_SLEEP_STATES = 2;
	localparam int DT_INTERNAL_STATES = 1;
	localparam int DT_EXC_STATES = 14;
	localparam int OSC_WAIT_STATES_DEF = 8192;

	typedef enum logic [1:0] {RUN_HIGH, RUN_MED, RUN_SUB} pmcg_run_type;

	typedef enum logic [3:0] {
		ST_RUN, ST_SLEEP, ST_WATCH, ST_STANDBY, ST_SUBSLEEP, ST_DT_OLD, ST_DT_WAIT, ST_DT_EXC
	} pmcg_state_type;

endpackage

// File: core/pmcg_top.sv
// Power-mode sequencer and peripheral clock gating with an APB register port.
// Assumes the CPU pulses the sleep strobe once per sleep instruction and that
// interrupt wake requests and the CPU mask bit are synchronous to CLOCK.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none

module pmcg_top
	import pmcg_pkg::*;
#(
	parameter int MED_DIV = 8,
	parameter int SUB_DIV = 4,
	parameter int OSC_WAIT_STATES = OSC_WAIT_STATES_DEF
)
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// cpu side
	input wire logic SLEEP_EXEC,
	input wire logic WAKE_IRQ,
	input wire logic CPU_IRQ_MASKED,
	output logic CPU_HALT,
	output logic DT_EXC_ACTIVE,
	output logic WATCH_MODE,
	output logic [1:0] RUN_MODE,
	output logic [7:0] SYS_DIV,
	output logic IRQ,
	// peripheral clocks
	output logic [8:0] PERIPH_CLK,
	output logic [8:0] PERIPH_STANDBY
);

	localparam int CNT_W = 24;

	// divisors outside 1 to 255 do not fit the SYS_DIV port
	if (MED_DIV < 1 || MED_DIV > 255 || SUB_DIV < 1 || SUB_DIV > 255)
	begin : bad_div_g
		$error("clock divisors must be 1 to 255");
	end
	// the longest wait and exception run must fit the state counter
	if (OSC_WAIT_STATES < 1 || (OSC_WAIT_STATES + DT_EXC_STATES) * MED_DIV >= 2 ** CNT_W)
	begin : bad_wait_g
		$error("oscillator wait too long for the counter");
	end

	logic [CTRL_WIDTH-1:0] ctrl_ff;
	logic [7:0] gate1_ff;
	logic [7:0] gate2_ff;
	logic [IRQ_WIDTH-1:0] irq_stat_ff;
	logic [IRQ_WIDTH-1:0] irq_mask_ff;
	pmcg_state_type state_ff;
	pmcg_state_type nxt_state;
	pmcg_run_type run_ff;
	pmcg_run_type nxt_run;
	pmcg_run_type tgt_ff;
	pmcg_run_type nxt_tgt;
	pmcg_run_type ret_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic [8:0] clk_en_ff;
	logic [IRQ_WIDTH-1:0] irq_set;
	logic [CNT_W-1:0] osc_states;

	logic standby_select;
	logic low_speed_select;
	logic medium_speed_select;
	logic direct_transfer_enable;
	logic timer_a_clock_source_bit;
	logic dt_allowed;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic [2:0] wait_shift;
	logic [8:0] gate_all;

	assign standby_select = ctrl_ff[CTRL_STANDBY_BIT];
	assign low_speed_select = ctrl_ff[CTRL_LOW_SPEED_BIT];
	assign medium_speed_select = ctrl_ff[CTRL_MED_SPEED_BIT];
	assign direct_transfer_enable = ctrl_ff[CTRL_DIRECT_BIT];
	assign timer_a_clock_source_bit = ctrl_ff[CTRL_TA_SOURCE_BIT];
	assign wait_shift = ctrl_ff[CTRL_WAIT_LSB +: 3];
	// the exception needs both the enable bit and an unmasked CPU
	assign dt_allowed = ctrl_ff[CTRL_DT_IRQ_EN_BIT] & ~CPU_IRQ_MASKED;

	// a shift that empties the wait still leaves one state, so the count cannot wrap
	always_comb
	begin
		osc_states = CNT_W'(OSC_WAIT_STATES >> wait_shift);
		if (osc_states == '0)
			osc_states = CNT_W'(1);
	end

	// cycles of CLOCK per CPU state in a run mode
	function automatic int div_of(input pmcg_run_type m);
		int d;
		d = 1;
		case (m)
			RUN_MED: d = MED_DIV;
			RUN_SUB: d = SUB_DIV;
			default: d = 1;
		endcase
		return d;
	endfunction

	// apb decode; every access completes in its first access cycle
	always_comb
	begin
		addr_ok = (PADDR == ADDR_CTRL) || (PADDR == ADDR_GATE1) || (PADDR == ADDR_GATE2)
			|| (PADDR == ADDR_MODE) || (PADDR == ADDR_IRQ_STAT) || (PADDR == ADDR_IRQ_MASK);
	end

	// zero wait states: read data is already registered in the setup cycle
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~addr_ok;
	assign wr_en = PSEL & PENABLE & PWRITE & addr_ok;
	assign rd_en = PSEL & ~PENABLE & ~PWRITE;

	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
			ctrl_ff <= CTRL_RESET;
		else if (wr_en && PADDR == ADDR_CTRL)
			ctrl_ff <= PWDATA[CTRL_WIDTH-1:0];
	end

	// gate registers: 0 stops, 1 runs
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
		begin
			gate1_ff <= GATE_RESET;
			gate2_ff <= GATE_RESET;
		end
		else if (wr_en)
		begin
			if (PADDR == ADDR_GATE1)
				gate1_ff <= PWDATA[7:0];
			if (PADDR == ADDR_GATE2)
				gate2_ff <= PWDATA[7:0];
		end
	end

	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
			irq_mask_ff <= '0;
		else if (wr_en && PADDR == ADDR_IRQ_MASK)
			irq_mask_ff <= PWDATA[IRQ_WIDTH-1:0];
	end

	// a set in the same cycle as a write-one clear wins
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
			irq_stat_ff <= '0;
		else if (wr_en && PADDR == ADDR_IRQ_STAT)
			irq_stat_ff <= (irq_stat_ff & ~PWDATA[IRQ_WIDTH-1:0]) | irq_set;
		else
			irq_stat_ff <= irq_stat_ff | irq_set;
	end

	assign IRQ = |(irq_stat_ff & irq_mask_ff);

	// read data is registered in the setup cycle
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
			PRDATA <= 32'h0000_0000;
		else if (rd_en)
		begin
			case (PADDR)
				ADDR_CTRL: PRDATA <= {21'h00000, ctrl_ff};
				ADDR_GATE1: PRDATA <= {24'h000000, gate1_ff};
				ADDR_GATE2: PRDATA <= {24'h000000, gate2_ff};
				ADDR_MODE: PRDATA <= {20'h00000, tgt_ff, 2'h0, 4'(state_ff), 2'h0, run_ff};
				ADDR_IRQ_STAT: PRDATA <= {29'h0000000, irq_stat_ff};
				ADDR_IRQ_MASK: PRDATA <= {29'h0000000, irq_mask_ff};
				default: PRDATA <= 32'h0000_0000;
			endcase
		end
	end

	// mode sequencer
	always_comb
	begin
		int old_cycles;
		int new_cycles;
		old_cycles = div_of(run_ff);
		new_cycles = div_of(tgt_ff);
		nxt_state = state_ff;
		nxt_run = run_ff;
		nxt_tgt = tgt_ff;
		nxt_cnt = cnt_ff;
		irq_set = '0;
		if (cnt_ff != '0)
			nxt_cnt = cnt_ff - CNT_W'(1);
		// sleep strobes count only in the run state; elsewhere they are dropped
		unique case (state_ff)
			ST_RUN:
			begin
				if (SLEEP_EXEC && run_ff != RUN_SUB)
				begin
					if (direct_transfer_enable && standby_select && low_speed_select && timer_a_clock_source_bit)
					begin
						nxt_tgt = RUN_SUB;
						nxt_state = ST_DT_OLD;
					end
					else if (direct_transfer_enable && !standby_select && !low_speed_select && (medium_speed_select == (run_ff == RUN_HIGH)))
					begin
						nxt_tgt = medium_speed_select ? RUN_MED : RUN_HIGH;
						nxt_state = ST_DT_OLD;
					end
					else if (!standby_select)
						nxt_state = ST_SLEEP;
					else if (timer_a_clock_source_bit)
						nxt_state = ST_WATCH;
					else
						nxt_state = ST_STANDBY;
				end
				else if (SLEEP_EXEC)
				begin
					if (direct_transfer_enable && standby_select && !low_speed_select && timer_a_clock_source_bit)
					begin
						nxt_tgt = medium_speed_select ? RUN_MED : RUN_HIGH;
						nxt_state = ST_DT_OLD;
					end
					else if (standby_select && timer_a_clock_source_bit)
						nxt_state = ST_WATCH;
					else if (!standby_select && low_speed_select && timer_a_clock_source_bit)
						nxt_state = ST_SUBSLEEP;
				end
				// sleep and internal states on the old clock
				if (nxt_state == ST_DT_OLD)
					nxt_cnt = CNT_W'((DT_SLEEP_STATES + DT_INTERNAL_STATES) * old_cycles - 1);
			end
			ST_DT_OLD:
			begin
				if (cnt_ff == '0)
				begin
					// no exception possible: fall back instead
					if (!dt_allowed)
					begin
						irq_set[IRQ_FALLBACK] = 1'b1;
						if (run_ff == RUN_SUB || tgt_ff == RUN_SUB)
							nxt_state = ST_WATCH;
						else
							nxt_state = ST_SLEEP;
					end
					else if (run_ff == RUN_SUB || tgt_ff == RUN_SUB)
					begin
						nxt_state = ST_DT_WAIT;
						// oscillator wait on the new clock
						if (tgt_ff != RUN_SUB)
							nxt_cnt = CNT_W'((int'(osc_states) * new_cycles) - 1);
						else
							nxt_cnt = '0;
					end
					else
					begin
						nxt_state = ST_DT_EXC;
						nxt_run = tgt_ff;
						nxt_cnt = CNT_W'(DT_EXC_STATES * new_cycles - 1);
					end
				end
			end
			ST_DT_WAIT:
			begin
				if (cnt_ff == '0)
				begin
					nxt_state = ST_DT_EXC;
					nxt_run = tgt_ff;
					// exception states on the new clock
					nxt_cnt = CNT_W'(DT_EXC_STATES * new_cycles - 1);
				end
			end
			ST_DT_EXC:
			begin
				if (cnt_ff == '0)
				begin
					nxt_state = ST_RUN;
					irq_set[IRQ_DT_DONE] = 1'b1;
				end
			end
			ST_SLEEP, ST_WATCH, ST_STANDBY, ST_SUBSLEEP:
			begin
				if (WAKE_IRQ)
				begin
					nxt_state = ST_RUN;
					irq_set[IRQ_WAKE] = 1'b1;
					if (state_ff == ST_SUBSLEEP || (state_ff == ST_WATCH && low_speed_select))
						nxt_run = RUN_SUB;
					else if (state_ff == ST_SLEEP)
						nxt_run = ret_ff;
					else
						nxt_run = medium_speed_select ? RUN_MED : RUN_HIGH;
				end
			end
			default:
				nxt_state = ST_RUN;
		endcase
	end

	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
		begin
			state_ff <= ST_RUN;
			run_ff <= RUN_MED;
			tgt_ff <= RUN_MED;
			cnt_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			run_ff <= nxt_run;
			tgt_ff <= nxt_tgt;
			cnt_ff <= nxt_cnt;
		end
	end

	// run mode to resume after a plain sleep
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
			ret_ff <= RUN_MED;
		else if (state_ff == ST_RUN || state_ff == ST_DT_EXC)
			ret_ff <= run_ff;
	end

	assign CPU_HALT = (state_ff != ST_RUN) && (state_ff != ST_DT_EXC);
	assign DT_EXC_ACTIVE = (state_ff == ST_DT_EXC);
	// watch phase of a subactive move
	assign WATCH_MODE = (state_ff == ST_WATCH) || (state_ff == ST_DT_WAIT);
	assign RUN_MODE = run_ff;
	assign SYS_DIV = 8'(div_of(run_ff));

	// chip standby and watch stop the peripherals the same way
	assign gate_all = {gate2_ff[GATE2_WATCHDOG], gate1_ff}
		& {9{(state_ff != ST_STANDBY) && (state_ff != ST_WATCH) && (state_ff != ST_DT_WAIT)}};

	// enables move on the falling edge so the AND gate cannot glitch
	always_ff @(negedge CLOCK)
	begin
		if (!RST_N)
			clk_en_ff <= 9'h1FF;
		else
			clk_en_ff <= gate_all;
	end

	assign PERIPH_CLK = {9{CLOCK}} & clk_en_ff;
	assign PERIPH_STANDBY = ~clk_en_ff;

endmodule

`default_nettype wire

// File: verif/pmcg_chk.sv
// checker for the power-mode and clock-gating block
// sees only the top-level ports; bound to the top module below
`timescale 1ns/100ps
`default_nettype none

module pmcg_chk
	import pmcg_pkg::*;
#(
	parameter int MED_DIV = 8,
	parameter int SUB_DIV = 4,
	parameter int OSC_WAIT_STATES = OSC_WAIT_STATES_DEF
)
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// apb
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	// cpu side
	input wire logic SLEEP_EXEC,
	input wire logic CPU_IRQ_MASKED,
	input wire logic CPU_HALT,
	input wire logic DT_EXC_ACTIVE,
	input wire logic WATCH_MODE,
	input wire logic [1:0] RUN_MODE,
	// peripheral clocks
	input wire logic [8:0] PERIPH_CLK,
	input wire logic [8:0] PERIPH_STANDBY
);
	logic [5:0] ctrl_ff;
	wire wr = PSEL && PENABLE && PWRITE;
	wire go = SLEEP_EXEC && !CPU_HALT && !DT_EXC_ACTIVE && !CPU_IRQ_MASKED;

	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (!RST_N);

	// mode bits are only seen as bus writes, so keep a shadow
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
			ctrl_ff <= 6'h00;
		else if (wr && PADDR == ADDR_CTRL)
			ctrl_ff <= PWDATA[5:0];
	end

	// enable value at each rising edge; a glitch-free gate keeps it until the falling edge
	logic [8:0] stby_rise;

	always_ff @(posedge CLOCK)
	begin
		stby_rise <= PERIPH_STANDBY;
	end

	gate_one_a: assert property (wr && PADDR == ADDR_GATE1 && !CPU_HALT
		|=> PERIPH_STANDBY[7:0] == ~$past(PWDATA[7:0])) else $error("gate 1 ignored");
	gate_dog_a: assert property (wr && PADDR == ADDR_GATE2 && !CPU_HALT
		|=> PERIPH_STANDBY[8] == !$past(PWDATA[0])) else $error("watchdog gate ignored");
	clk_stop_a: assert property (@(negedge CLOCK) disable iff (!RST_N)
		PERIPH_STANDBY == stby_rise && PERIPH_CLK == ~PERIPH_STANDBY)
		else $error("gate moved while clock high");
	watch_stop_a: assert property (WATCH_MODE |-> PERIPH_STANDBY == 9'h1FF)
		else $error("clocks run in watch");
	hi_med_a: assert property (go && RUN_MODE == 2'd0 && (ctrl_ff & 6'h2F) == 6'h2C
		|=> CPU_HALT[*3] ##1 (DT_EXC_ACTIVE && RUN_MODE == 2'd1)[*8])
		else $error("high to medium");
	med_hi_a: assert property (go && RUN_MODE == 2'd1 && (ctrl_ff & 6'h2F) == 6'h28
		|=> CPU_HALT[*8] ##16 CPU_HALT ##1 (DT_EXC_ACTIVE && RUN_MODE == 2'd0)[*7]
		##7 DT_EXC_ACTIVE ##1 !DT_EXC_ACTIVE) else $error("medium to high");
	to_sub_a: assert property (go && RUN_MODE == 2'd0 && (ctrl_ff & 6'h3B) == 6'h3B
		|=> CPU_HALT[*3] ##1 WATCH_MODE ##1 (DT_EXC_ACTIVE && RUN_MODE == 2'd2))
		else $error("high to subactive");
	sub_hi_a: assert property (go && RUN_MODE == 2'd2 && ctrl_ff == 6'h39
		|=> CPU_HALT[*8] ##4 CPU_HALT ##1 (WATCH_MODE && CPU_HALT)
		##[16:300] (DT_EXC_ACTIVE && RUN_MODE == 2'd0)) else $error("subactive to high");
	fall_a: assert property (go && RUN_MODE != 2'd2 && (ctrl_ff & 6'h2B) == 6'h08
		|=> (CPU_HALT && !DT_EXC_ACTIVE)[*5] ##25 (CPU_HALT && !DT_EXC_ACTIVE))
		else $error("no fallback");
endmodule

bind pmcg_top pmcg_chk
	#(.MED_DIV(MED_DIV), .SUB_DIV(SUB_DIV), .OSC_WAIT_STATES(OSC_WAIT_STATES))
	chk_u (
		.CLOCK(CLOCK),
		.RST_N(RST_N),
		.PSEL(PSEL),
		.PENABLE(PENABLE),
		.PWRITE(PWRITE),
		.PADDR(PADDR),
		.PWDATA(PWDATA),
		.SLEEP_EXEC(SLEEP_EXEC),
		.CPU_IRQ_MASKED(CPU_IRQ_MASKED),
		.CPU_HALT(CPU_HALT),
		.DT_EXC_ACTIVE(DT_EXC_ACTIVE),
		.WATCH_MODE(WATCH_MODE),
		.RUN_MODE(RUN_MODE),
		.PERIPH_CLK(PERIPH_CLK),
		.PERIPH_STANDBY(PERIPH_STANDBY)
	);

`default_nettype wire

// File: verif/pmcg_cpu_model.sv
// cpu core model: issues sleep strobes and wake requests
// tasks are entered just after a rising edge of CLOCK
`timescale 1ns/100ps
`default_nettype none

module pmcg_cpu_model (
	// clock
	input wire logic CLOCK,
	// status from the block
	input wire logic CPU_HALT,
	input wire logic DT_EXC_ACTIVE,
	// requests to the block
	output logic SLEEP_EXEC,
	output logic WAKE_IRQ,
	output logic CPU_IRQ_MASKED
);
	initial
	begin
		SLEEP_EXEC = 1'b0;
		WAKE_IRQ = 1'b0;
		CPU_IRQ_MASKED = 1'b0;
	end

	task automatic sleep_pulse;
		SLEEP_EXEC <= 1'b1;
		@(posedge CLOCK);
		SLEEP_EXEC <= 1'b0;
	endtask

	task automatic wake_pulse;
		WAKE_IRQ <= 1'b1;
		@(posedge CLOCK);
		WAKE_IRQ <= 1'b0;
	endtask

	// cycles held off; bounded so a stuck mode cannot hang the run
	task automatic run_sleep(output int n);
		n = 0;
		sleep_pulse();
		@(negedge CLOCK);
		while ((CPU_HALT || DT_EXC_ACTIVE) && n < 2000)
		begin
			n++;
			@(negedge CLOCK);
		end
		@(posedge CLOCK);
	endtask
endmodule

`default_nettype wire

// File: verif/pmcg_test.sv
// self-checking bench for the power-mode and clock-gating block
// one clock; the oscillator wait is cut to 16 states
`timescale 1ns/100ps
`default_nettype none

module pmcg_test
	import pmcg_pkg::*;
;
	logic CLOCK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
	logic SLEEP_EXEC, WAKE_IRQ, CPU_IRQ_MASKED, CPU_HALT, DT_EXC_ACTIVE, WATCH_MODE, IRQ;
	logic [1:0] RUN_MODE;
	logic [7:0] PADDR, SYS_DIV;
	logic [8:0] PERIPH_CLK, PERIPH_STANDBY;
	logic [31:0] PWDATA, PRDATA, rdata;
	int n_errors = 0;
	int checks = 0;
	int n;
	localparam logic [5:0] CT [6] = '{6'h28, 6'h2C, 6'h3B, 6'h39, 6'h3B, 6'h3D};
	localparam logic [1:0] MD [6] = '{2'd0, 2'd1, 2'd2, 2'd0, 2'd2, 2'd1};
	localparam int NC [6] = '{38, 115, 81, 42, 60, 252};
	// cycles per CPU state for the mode reached: high 1, medium 8, subactive 4
	localparam logic [7:0] SD [6] = '{8'h01, 8'h08, 8'h04, 8'h01, 8'h04, 8'h08};

	pmcg_top #(.OSC_WAIT_STATES(16)) dut_u (.*);
	pmcg_cpu_model cpu_u (.*);

	initial
	begin
		CLOCK = 1'b0;
		forever #20 CLOCK = ~CLOCK;
	end

	task automatic final_report;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// request held until ready is seen high at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		@(posedge CLOCK);
		while (PREADY !== 1'b1 && k < 100)
		begin
			k++;
			@(posedge CLOCK);
		end
		rdata = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLOCK);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdata & m, e);
	endtask

	// standby flags move on the falling edge, so look two falling edges on
	task automatic stby(input logic [8:0] e);
		repeat (2) @(negedge CLOCK);
		chk({23'h0, PERIPH_STANDBY}, {23'h0, e});
		@(posedge CLOCK);
	endtask

	initial
	begin
		RST_N = 1'b0;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 8'h00;
		PWDATA = 32'h0;
		repeat (8) @(posedge CLOCK);
		RST_N <= 1'b1;
		@(posedge CLOCK);
		rd(ADDR_GATE1, 32'hFFFFFFFF, 32'hFF);
		rd(ADDR_GATE2, 32'hFFFFFFFF, 32'hFF);
		for (int i = 0; i < 9; i++)
		begin
			apb(1'b1, i < 8 ? ADDR_GATE1 : ADDR_GATE2, ~(32'h1 << i % 8));
			stby(9'h1 << i);
			apb(1'b1, i < 8 ? ADDR_GATE1 : ADDR_GATE2, 32'hFF);
			stby(9'h000);
		end
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b1, ADDR_CTRL, {26'h0, CT[i]});
			cpu_u.run_sleep(n);
			chk(n, NC[i]);
			chk({24'h0, SYS_DIV}, {24'h0, SD[i]});
			rd(ADDR_MODE, 32'h3, {30'h0, MD[i]});
			rd(ADDR_IRQ_STAT, 32'h1, 32'h1);
			apb(1'b1, ADDR_IRQ_STAT, 32'h1);
		end
		apb(1'b1, ADDR_IRQ_MASK, 32'h2);
		apb(1'b1, ADDR_CTRL, 32'h08);
		cpu_u.sleep_pulse();
		// the fallback is only taken after the 24 old-clock cycles of the sleep and internal states
		repeat (30) @(posedge CLOCK);
		rd(ADDR_MODE, 32'hF3, 32'h11);
		@(negedge CLOCK);
		chk({30'h0, CPU_HALT, IRQ}, 32'h3);
		@(posedge CLOCK);
		apb(1'b1, ADDR_IRQ_MASK, 32'h0);
		@(negedge CLOCK);
		chk({31'h0, IRQ}, 32'h0);
		@(posedge CLOCK);
		cpu_u.wake_pulse();
		rd(ADDR_MODE, 32'hF3, 32'h01);
		rd(ADDR_IRQ_STAT, 32'h7, 32'h6);
		apb(1'b1, ADDR_IRQ_STAT, 32'h7);
		rd(ADDR_IRQ_STAT, 32'h7, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rdata, 32'h0);
		final_report();
	end

	initial
	begin
		repeat (20000) @(posedge CLOCK);
		n_errors++;
		$display("ERROR %0t: timeout", $time);
		final_report();
	end
endmodule

`default_nettype wire
